// ---- hw/pd_fwd_pkg.sv ----
/*
  Shared constants, types and the message classifier for the cable-plug
  message forwarder. Assumes header fields laid out as in the PD header word.
*/
package pd_fwd_pkg;

  localparam logic [1:0] SOP_PLAIN = 2'h0;
  localparam logic [1:0] SOP_PRIME = 2'h1;
  localparam logic [1:0] SOP_DPRIME = 2'h2;

  localparam int HDR_TYPE_LSB = 0;
  localparam int HDR_TYPE_MSB = 4;
  localparam int HDR_NOBJ_LSB = 12;
  localparam int HDR_NOBJ_MSB = 14;
  localparam int HDR_EXT_BIT = 15;
  localparam int HDR_W = 16;
  localparam int VDM_W = 5;
  localparam int FWD_W = 1 + 2 + VDM_W + HDR_W;

  // Control message types
  localparam logic [4:0] CT_GOODCRC = 5'h01;
  localparam logic [4:0] CT_DR_SWAP = 5'h09;
  localparam logic [4:0] CT_WAIT = 5'h0c;
  localparam logic [4:0] CT_NOT_SUPPORTED = 5'h10;
  localparam logic [4:0] CT_GET_STATUS = 5'h12;
  localparam logic [4:0] CT_GET_COUNTRY_CODES = 5'h13;
  // Data message types
  localparam logic [4:0] DT_SOURCE_CAPS = 5'h01;
  localparam logic [4:0] DT_BIST = 5'h03;
  localparam logic [4:0] DT_BATTERY_STATUS = 5'h05;
  localparam logic [4:0] DT_ALERT = 5'h06;
  localparam logic [4:0] DT_GET_COUNTRY_INFO = 5'h07;
  localparam logic [4:0] DT_VENDOR = 5'h0f;
  // Extended message types
  localparam logic [4:0] XT_STATUS = 5'h02;
  localparam logic [4:0] XT_GET_BATTERY_CAP = 5'h03;
  localparam logic [4:0] XT_GET_BATTERY_STATUS = 5'h04;
  localparam logic [4:0] XT_BATTERY_CAPS = 5'h05;
  localparam logic [4:0] XT_GET_MFR_INFO = 5'h06;
  localparam logic [4:0] XT_MFR_INFO = 5'h07;
  localparam logic [4:0] XT_SECURITY_REQ = 5'h08;
  localparam logic [4:0] XT_SECURITY_RESP = 5'h09;
  localparam logic [4:0] XT_FW_UPDATE_REQ = 5'h0a;
  localparam logic [4:0] XT_FW_UPDATE_RESP = 5'h0b;
  localparam logic [4:0] XT_COUNTRY_INFO = 5'h0d;
  localparam logic [4:0] XT_COUNTRY_CODES = 5'h0e;
  // Vendor defined commands
  localparam logic [4:0] VDM_DISC_IDENTITY = 5'h01;
  localparam logic [4:0] VDM_DISC_SVIDS = 5'h02;
  localparam logic [4:0] VDM_DISC_MODES = 5'h03;
  localparam logic [4:0] VDM_ENTER_MODE = 5'h04;
  localparam logic [4:0] VDM_EXIT_MODE = 5'h05;
  localparam logic [4:0] VDM_ATTENTION = 5'h06;

  // Timing and buffer depth
  localparam longint CLK_HZ = 200000000;
  localparam longint FORWARD_LATENCY_LIMIT_MS = 4;
  localparam longint ACK_LIMIT_US = 195;
  localparam longint BOOT_ACK_HOLDOFF_LIMIT_MS = 50;
  localparam longint ROLE_SWAP_RETRY_DELAY_MS = 100;
  localparam int FORWARD_CYCLES = int'(FORWARD_LATENCY_LIMIT_MS * CLK_HZ / 1000);
  localparam int ACK_CYCLES = int'(ACK_LIMIT_US * CLK_HZ / 1000000);
  localparam int HOLDOFF_CYCLES = int'(BOOT_ACK_HOLDOFF_LIMIT_MS * CLK_HZ / 1000);
  localparam int SWAP_RETRY_CYCLES = int'((ROLE_SWAP_RETRY_DELAY_MS * CLK_HZ + 999) / 1000);
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {ROUTE_DROP, ROUTE_LOCAL, ROUTE_FWD} route_t;

  function automatic route_t classify(input logic [1:0] sop, input logic [HDR_W-1:0] hdr,
                                      input logic [VDM_W-1:0] cmd, input logic altOk);
    logic ext;
    logic ctrl;
    logic data;
    logic [4:0] t;
    logic sopList;
    logic dprimeList;
    ext = hdr[HDR_EXT_BIT];
    ctrl = !ext && (hdr[HDR_NOBJ_MSB:HDR_NOBJ_LSB] == 3'h0);
    data = !ext && !ctrl;
    t = hdr[HDR_TYPE_MSB:HDR_TYPE_LSB];
    sopList = (ctrl && (t inside {CT_DR_SWAP, CT_GET_COUNTRY_CODES, CT_GET_STATUS, CT_NOT_SUPPORTED, CT_WAIT}))
      || (data && (t inside {DT_GET_COUNTRY_INFO, DT_BATTERY_STATUS, DT_ALERT}))
      || (data && t == DT_VENDOR && (cmd inside {VDM_DISC_IDENTITY, VDM_DISC_SVIDS, VDM_DISC_MODES,
                                                 VDM_ENTER_MODE, VDM_EXIT_MODE, VDM_ATTENTION}))
      || (ext && (t inside {XT_STATUS, XT_GET_BATTERY_CAP, XT_GET_BATTERY_STATUS, XT_BATTERY_CAPS,
                            XT_GET_MFR_INFO, XT_MFR_INFO, XT_SECURITY_REQ, XT_SECURITY_RESP,
                            XT_FW_UPDATE_REQ, XT_FW_UPDATE_RESP, XT_COUNTRY_INFO, XT_COUNTRY_CODES}));
    dprimeList = (ext && (t inside {XT_FW_UPDATE_REQ, XT_FW_UPDATE_RESP, XT_SECURITY_REQ, XT_SECURITY_RESP,
                                    XT_STATUS}))
      || (altOk && data && t == DT_VENDOR && (cmd inside {VDM_ENTER_MODE, VDM_EXIT_MODE, VDM_ATTENTION}));
    unique case (sop)
      SOP_PLAIN: classify = sopList ? ROUTE_FWD : ROUTE_LOCAL;
      SOP_PRIME: classify = ROUTE_LOCAL;
      SOP_DPRIME: classify = dprimeList ? ROUTE_FWD : ROUTE_DROP;
      default: classify = ROUTE_DROP;
    endcase
  endfunction

  function automatic logic isExempt(input logic [HDR_W-1:0] hdr);
    isExempt = hdr[HDR_EXT_BIT] && (hdr[HDR_TYPE_MSB:HDR_TYPE_LSB] inside
      {XT_FW_UPDATE_REQ, XT_FW_UPDATE_RESP, XT_SECURITY_REQ, XT_SECURITY_RESP});
  endfunction

endpackage

// ---- hw/fwd_buffer.sv ----
/*
  Small valid/ready buffer for forwarded message headers.
  Assumes one clock; flush empties it in one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module fwd_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign inReady = (count != FULL);
  assign outData = store[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wrPtr] <= inData;
    end
  end

  // Valid is its own flip-flop so the stream output leaves a register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      outValid <= 1'b0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      outValid <= 1'b0;
    end else begin
      if (push) wrPtr <= bump(wrPtr);
      if (pop) rdPtr <= bump(rdPtr);
      if (push && !pop) begin
        count <= count + 1'b1;
        outValid <= 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
        outValid <= (count != CW'(1));
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/pd_cable_message_forwarder.sv ----
/*
  Active-state message handler of one plug of an optical_isolated_active_cable:
  routes received messages locally, drops them or forwards them to the far plug.
  Assumes the receive PHY and the link logic share mclk and present one
  decoded message header per rxValid pulse.
*/
// What this block does
// - SOP' and invalid messages never cross
// - Listed SOP messages forwarded to far plug
// - Local GoodCRC for each valid non-GoodCRC message, promptly unless held, none for one arriving at hold-off release
// - Accept messages back to back
// - Forwarding beyond four milliseconds window flagged on forwardLate, one non-exempt message at a time
// - Only listed SOP'' messages are forwarded
// - No forwarding before third initialization phase ends
// - No reply if responder gave no GoodCRC
// - Wait after role swap delays next swap
// - Phase three GoodCRC hold-off, at most 50 ms
// - Unlisted SOP'' traffic may be dropped
// - GoodCRC and BIST: SOP' handled, SOP'' ignored
// - SOP'' answers may come from local copy
// - Hard Reset relayed, then state returns initial
// - Cable Reset has no effect
`timescale 1ns/100ps
`default_nettype none
module pd_cable_message_forwarder import pd_fwd_pkg::*; #(
  parameter int FWD_CYCLES = FORWARD_CYCLES,
  parameter int HOLD_CYCLES = HOLDOFF_CYCLES,
  parameter int RETRY_CYCLES = SWAP_RETRY_CYCLES,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rxValid,
  input wire logic rxCrcOk,
  input wire logic [1:0] rxSop,
  input wire logic [HDR_W-1:0] rxHeader,
  input wire logic [VDM_W-1:0] rxVdmCmd,
  input wire logic rxHardReset,
  input wire logic rxCableReset,
  input wire logic initDone,
  input wire logic phase3Active,
  input wire logic ackRelease,
  input wire logic altModeOk,
  input wire logic farDriven,
  input wire logic farNoAck,
  input wire logic fwdReady,
  output logic goodCrcSend,
  output logic [1:0] goodCrcSop,
  output logic fwdValid,
  output logic fwdExempt,
  output logic [1:0] fwdSop,
  output logic [VDM_W-1:0] fwdVdmCmd,
  output logic [HDR_W-1:0] fwdHeader,
  output logic localValid,
  output logic [1:0] localSop,
  output logic [HDR_W-1:0] localHeader,
  output logic dropPulse,
  output logic overflowDrop,
  output logic forwardLate,
  output logic hardResetRelay,
  output logic replySuppressed
);
  localparam int FCW = $clog2(FWD_CYCLES + 1);
  localparam int HCW = $clog2(HOLD_CYCLES + 1);
  localparam int RCW = $clog2(RETRY_CYCLES + 1);

  route_t route;
  logic good;
  logic [4:0] msgType;
  logic isCtrl;
  logic isGoodCrc;
  logic isSrcCaps;
  logic isSwap;
  logic isWait;
  logic swapBlocked;
  logic wantFwd;
  logic pushReady;
  logic bufValid;
  logic [FWD_W-1:0] bufData;
  logic holding;
  logic [1:0] holdSop;
  logic [HCW-1:0] holdCount;
  logic [FCW-1:0] fwdCount;
  logic fwdTiming;
  logic fwdTimingExempt;
  logic swapSeen;
  logic [RCW-1:0] retryCount;

  // Cable Reset is deliberately not decoded anywhere
  assign good = rxValid && rxCrcOk;
  assign route = classify(rxSop, rxHeader, rxVdmCmd, altModeOk);
  assign msgType = rxHeader[HDR_TYPE_MSB:HDR_TYPE_LSB];
  assign isCtrl = !rxHeader[HDR_EXT_BIT] && (rxHeader[HDR_NOBJ_MSB:HDR_NOBJ_LSB] == 3'h0);
  assign isGoodCrc = isCtrl && msgType == CT_GOODCRC;
  assign isSrcCaps = !rxHeader[HDR_EXT_BIT] && !isCtrl && msgType == DT_SOURCE_CAPS && rxSop == SOP_PLAIN;
  assign isSwap = isCtrl && msgType == CT_DR_SWAP && rxSop == SOP_PLAIN;
  assign isWait = isCtrl && msgType == CT_WAIT && rxSop == SOP_PLAIN;
  assign swapBlocked = isSwap && retryCount != '0;
  assign wantFwd = good && !rxHardReset && route == ROUTE_FWD && initDone && !swapBlocked;

  fwd_buffer #(.WIDTH(FWD_W), .DEPTH(DEPTH)) buffer (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(rxHardReset),
    .inValid(wantFwd),
    .inReady(pushReady),
    .inData({isExempt(rxHeader), rxSop, rxVdmCmd, rxHeader}),
    .outValid(bufValid),
    .outReady(fwdReady),
    .outData(bufData)
  );
  assign fwdValid = bufValid;
  assign {fwdExempt, fwdSop, fwdVdmCmd, fwdHeader} = bufData;

  // GoodCRC one edge after the message, or after hold-off release
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      goodCrcSend <= 1'b0;
      goodCrcSop <= SOP_PLAIN;
    end else if (rxHardReset) begin
      goodCrcSend <= 1'b0;
    end else if (holding && (ackRelease || holdCount == HCW'(HOLD_CYCLES))) begin
      goodCrcSend <= 1'b1;
      goodCrcSop <= holdSop;
    end else if (good && !isGoodCrc && !(phase3Active && isSrcCaps)) begin
      goodCrcSend <= 1'b1;
      goodCrcSop <= rxSop;
    end else begin
      goodCrcSend <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      holding <= 1'b0;
      holdSop <= SOP_PLAIN;
      holdCount <= '0;
    end else if (rxHardReset || (holding && (ackRelease || holdCount == HCW'(HOLD_CYCLES)))) begin
      holding <= 1'b0;
      holdCount <= '0;
    end else if (good && phase3Active && isSrcCaps) begin
      holding <= 1'b1;
      holdSop <= rxSop;
      holdCount <= '0;
    end else if (holding) begin
      holdCount <= holdCount + 1'b1;
    end
  end

  // Local answers and drops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      localValid <= 1'b0;
      localSop <= SOP_PLAIN;
      localHeader <= '0;
      dropPulse <= 1'b0;
      overflowDrop <= 1'b0;
    end else begin
      localValid <= good && !rxHardReset && route == ROUTE_LOCAL;
      if (good && route == ROUTE_LOCAL) begin
        localSop <= rxSop;
        localHeader <= rxHeader;
      end
      dropPulse <= rxValid && !rxHardReset && (!rxCrcOk || route == ROUTE_DROP || swapBlocked
        || (route == ROUTE_FWD && !initDone));
      overflowDrop <= wantFwd && !pushReady;
    end
  end

  // Forward window supervision on one message at a time: the one pushed while no window is running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fwdTiming <= 1'b0;
      fwdTimingExempt <= 1'b0;
      fwdCount <= '0;
      forwardLate <= 1'b0;
    end else begin
      forwardLate <= 1'b0;
      if (rxHardReset || farDriven) begin
        fwdTiming <= 1'b0;
        fwdCount <= '0;
      end else if (!fwdTiming && wantFwd && pushReady) begin
        fwdTiming <= 1'b1;
        fwdTimingExempt <= isExempt(rxHeader);
        fwdCount <= '0;
      end else if (fwdTiming) begin
        if (fwdCount == FCW'(FWD_CYCLES - 1) && !fwdTimingExempt) begin
          forwardLate <= 1'b1;
          fwdTiming <= 1'b0;
        end
        fwdCount <= fwdCount + 1'b1;
      end
    end
  end

  // Retry delay after a Wait answered a forwarded role swap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      swapSeen <= 1'b0;
      retryCount <= '0;
    end else if (rxHardReset) begin
      swapSeen <= 1'b0;
      retryCount <= '0;
    end else begin
      if (wantFwd && isSwap) swapSeen <= 1'b1;
      else if (good && isWait) swapSeen <= 1'b0;
      if (good && isWait && swapSeen) retryCount <= RCW'(RETRY_CYCLES);
      else if (retryCount != '0) retryCount <= retryCount - 1'b1;
    end
  end

  // Reply path gate and hard reset relay
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      replySuppressed <= 1'b0;
      hardResetRelay <= 1'b0;
    end else begin
      hardResetRelay <= rxHardReset;
      if (farNoAck) replySuppressed <= 1'b1;
      else if (rxHardReset || good) replySuppressed <= 1'b0;
    end
  end

  a_crc_ack_prompt: assert property (@(posedge mclk) disable iff (!reset_n)
    (good && !rxHardReset && !isGoodCrc && !(phase3Active && isSrcCaps) && !holding) |=> goodCrcSend)
    else $error("GoodCRC not sent one cycle after valid message");
  a_bad_crc_silent: assert property (@(posedge mclk) disable iff (!reset_n)
    (rxValid && !rxCrcOk && !holding && !rxHardReset) |=> (!goodCrcSend && !localValid && dropPulse))
    else $error("Bad CRC message was answered");
  a_prime_stays: assert property (@(posedge mclk) disable iff (!reset_n)
    (rxValid && rxSop == SOP_PRIME) |-> !wantFwd)
    else $error("SOP prime message entered forward path");
  a_init_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
    (!initDone && good && !rxHardReset && route == ROUTE_FWD) |=> (dropPulse && !$rose(fwdValid)))
    else $error("Forwarded before initialization done");
  a_holdoff_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    (holding && holdCount == HCW'(HOLD_CYCLES) && !rxHardReset) |=> (goodCrcSend && !holding))
    else $error("GoodCRC hold-off exceeded its limit");
  a_hard_relay: assert property (@(posedge mclk) disable iff (!reset_n)
    rxHardReset |=> (hardResetRelay && !bufValid && !holding && retryCount == '0))
    else $error("Hard Reset not relayed or state not cleared");
  a_no_reply_noack: assert property (@(posedge mclk) disable iff (!reset_n)
    (farNoAck && !good) |=> replySuppressed)
    else $error("Reply not suppressed after missing GoodCRC");
  a_swap_wait: assert property (@(posedge mclk) disable iff (!reset_n)
    (good && isWait && swapSeen && !rxHardReset) |=> (retryCount == RCW'(RETRY_CYCLES)))
    else $error("Role swap retry delay not started");
  a_dprime_filter: assert property (@(posedge mclk) disable iff (!reset_n)
    (wantFwd && rxSop == SOP_DPRIME && !rxHeader[HDR_EXT_BIT]) |-> (altModeOk && msgType == DT_VENDOR))
    else $error("Unlisted SOP double-prime message forwarded");
  a_window_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    forwardLate |-> $past(fwdTiming) && !$past(fwdTimingExempt) && !$past(farDriven))
    else $error("Forward window flag without cause");
  a_cable_reset_inert: assert property (@(posedge mclk) disable iff (!reset_n)
    (rxCableReset && !rxValid && !rxHardReset && !holding) |=> (!goodCrcSend && !hardResetRelay))
    else $error("Cable Reset had an effect");

  c_forward: cover property (@(posedge mclk) disable iff (!reset_n) fwdValid && fwdReady);
  c_back_to_back: cover property (@(posedge mclk) disable iff (!reset_n) wantFwd ##1 wantFwd);
  c_holdoff_release: cover property (@(posedge mclk) disable iff (!reset_n) holding && ackRelease);
  c_overflow: cover property (@(posedge mclk) disable iff (!reset_n) overflowDrop);
endmodule
`default_nettype wire

// ---- test/far_plug_model.sv ----
/*
  Far-side model of the fiber link and far plug: accepts forwarded message
  headers and reports when each was driven on the far line.
  Assumes the forwarder's clock and reset; one message in flight at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module far_plug_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic fwdValid,
  output logic fwdReady,
  output logic farDriven,
  output logic farNoAck,
  input wire logic stall,
  input wire logic noAck,
  input wire logic [7:0] delay
);
  logic busy;
  logic [7:0] cnt;

  // One message in flight, so farDriven always names the oldest
  assign fwdReady = !stall && !busy;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      farDriven <= 1'b0;
      farNoAck <= 1'b0;
    end else begin
      farDriven <= 1'b0;
      farNoAck <= 1'b0;
      if (fwdValid && fwdReady) begin
        busy <= 1'b1;
        cnt <= delay;
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy <= 1'b0;
        farDriven <= 1'b1;
        farNoAck <= noAck;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Self-checking bench for the cable-plug message forwarder.
  Assumes the far-plug model on the forward stream and shortened timer parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top import pd_fwd_pkg::*;;
  localparam int FWDC = 50;
  localparam int HOLDC = 40;
  localparam int RETRYC = 60;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic rxValid, rxCrcOk, rxHardReset, rxCableReset, initDone, phase3Active, ackRelease, altModeOk;
  logic [1:0] rxSop;
  logic [15:0] rxHeader;
  logic [4:0] rxVdmCmd;
  logic farDriven, farNoAck, fwdReady, goodCrcSend, fwdValid, fwdExempt, localValid, dropPulse;
  logic overflowDrop, forwardLate, hardResetRelay, replySuppressed, stall, noAck, expOv, swapBlocked;
  logic [1:0] goodCrcSop, fwdSop, localSop;
  logic [4:0] fwdVdmCmd;
  logic [15:0] fwdHeader, localHeader;
  logic [17:0] curMsg, pipeMsg;
  logic [7:0] farDelay;
  logic [6:0] curExp, pipeExp;
  logic [23:0] expQ[$];
  int seed = 32'h6ef72af8;
  int nFail = 0;
  int nCompared = 0;
  int lateCnt = 0;
  int n;

  always #2.5 mclk = ~mclk;

  pd_cable_message_forwarder #(.FWD_CYCLES(FWDC), .HOLD_CYCLES(HOLDC), .RETRY_CYCLES(RETRYC), .DEPTH(2))
    pd_cable_message_forwarder_i (.mclk, .reset_n, .rxValid, .rxCrcOk, .rxSop, .rxHeader, .rxVdmCmd,
    .rxHardReset, .rxCableReset, .initDone, .phase3Active, .ackRelease, .altModeOk, .farDriven, .farNoAck,
    .fwdReady, .goodCrcSend, .goodCrcSop, .fwdValid, .fwdExempt, .fwdSop, .fwdVdmCmd, .fwdHeader,
    .localValid, .localSop, .localHeader, .dropPulse, .overflowDrop, .forwardLate, .hardResetRelay,
    .replySuppressed);

  far_plug_model far_plug_model_i (.mclk, .reset_n, .fwdValid, .fwdReady, .farDriven, .farNoAck, .stall,
    .noAck, .delay(farDelay));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic finalReport();
    if (nFail == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // 0 drop, 1 local, 2 forward
  function automatic logic [1:0] expRoute(input logic [1:0] sop, input logic [15:0] h, input logic [4:0] c);
    logic ctrl;
    logic data;
    logic sl;
    logic dl;
    ctrl = h[15:12] == 4'h0;
    data = !h[15] && !ctrl;
    sl = (ctrl && h[4:0] inside {5'h09, 5'h0c, 5'h10, 5'h12, 5'h13}) || (data && h[4:0] inside {[5'h05:5'h07]})
      || (data && h[4:0] == 5'h0f && c inside {[5'h01:5'h06]}) || (h[15] && h[4:0] inside {[5'h02:5'h0b], 5'h0d, 5'h0e});
    dl = (h[15] && h[4:0] inside {[5'h08:5'h0b], 5'h02}) || (altModeOk && data && h[4:0] == 5'h0f && c inside {[5'h04:5'h06]});
    if (sop == 2'h1) return 2'h1;
    if (sop == 2'h0) return sl ? 2'h2 : 2'h1;
    return (sop == 2'h2 && dl) ? 2'h2 : 2'h0;
  endfunction

  task automatic step(input int k);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic idle(input int k);
    rxValid = 1'b0;
    curExp = '0;
    step(k);
  endtask

  task automatic send(input logic [1:0] sop, input logic [15:0] h, input logic [4:0] c, input logic ok, input int gap);
    logic [1:0] r;
    logic g;
    r = ok ? expRoute(sop, h, c) : 2'h0;
    if (r == 2'h2 && (!initDone || (swapBlocked && h == 16'h0009))) r = 2'h0;
    g = ok && !(h[15:12] == 4'h0 && h[4:0] == 5'h01) && !(phase3Active && sop == 2'h0 && h[15:12] == 4'h1 && h[4:0] == 5'h01);
    if (r == 2'h2 && !expOv) expQ.push_back({h[15] && h[4:0] inside {[5'h08:5'h0b]}, sop, c, h});
    {rxValid, rxSop, rxHeader, rxVdmCmd, rxCrcOk} = {1'b1, sop, h, c, ok};
    curExp = {1'b1, g, g ? sop : 2'h0, r == 2'h1, r == 2'h0, expOv};
    curMsg = {sop, h};
    step(1);
    if (gap > 0) idle(gap);
  endtask

  task automatic randomRun(input int k);
    logic [31:0] v;
    logic [15:0] h;
    for (int i = 0; i < k; i++) begin
      v = $random(seed);
      h = $random(seed);
      if (h[15:12] == 4'h0 && h[4:0] == 5'h09) h[4:0] = 5'h0a;
      altModeOk = v[15];
      send(v[1:0], h, v[12:8], v[7:2] != 6'h0, 1 + int'(v[14:13]));
    end
  endtask

  always @(posedge mclk) pipeExp <= curExp;
  always @(posedge mclk) pipeMsg <= curMsg;

  always @(negedge mclk) begin
    if (reset_n && pipeExp[6]) begin
      check({goodCrcSend, goodCrcSop & {2{goodCrcSend}}, localValid, dropPulse, overflowDrop}, pipeExp[5:0]);
    end
    if (reset_n && pipeExp[6] && pipeExp[2]) check({localSop, localHeader}, pipeMsg);
    if (reset_n && fwdValid === 1'b1 && fwdReady === 1'b1) begin
      if (expQ.size() == 0) check(32'h1, 32'h0);
      else check({fwdExempt, fwdSop, fwdVdmCmd, fwdHeader}, expQ.pop_front());
    end
    if (reset_n && forwardLate === 1'b1) lateCnt++;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    nFail++;
    finalReport();
  end

  initial begin
    {rxValid, rxCrcOk, rxHardReset, rxCableReset, initDone, phase3Active, ackRelease, altModeOk} = '0;
    {rxSop, rxHeader, rxVdmCmd, stall, noAck, farDelay, curExp, expOv, swapBlocked} = '0;
    repeat (12) @(posedge mclk);
    #1 reset_n = 1'b1;
    check({goodCrcSend, fwdValid, localValid, dropPulse, overflowDrop, forwardLate, hardResetRelay, replySuppressed}, 0);
    randomRun(40);
    initDone = 1'b1;
    for (int a = 0; a < 2; a++) begin
      altModeOk = a[0];
      for (int s = 0; s < 3; s++) begin
        for (int t = 0; t < 32; t++) begin
          send(s[1:0], {4'h9, 7'h0, t[4:0]}, 5'h0, 1'b1, 1);
          send(s[1:0], {4'h1, 7'h0, t[4:0]}, t[4:0], 1'b1, 1);
          if (t != 9) send(s[1:0], {4'h0, 7'h0, t[4:0]}, 5'h0, 1'b1, 0);
        end
      end
    end
    idle(2);
    randomRun(200);
    stall = 1'b1;
    send(2'h0, 16'h0012, 5'h0, 1'b1, 1);
    send(2'h0, 16'h0013, 5'h0, 1'b1, 1);
    expOv = 1'b1;
    send(2'h0, 16'h0012, 5'h0, 1'b1, 1);
    expOv = 1'b0;
    stall = 1'b0;
    step(10);
    farDelay = 8'd70;
    send(2'h0, 16'h0012, 5'h0, 1'b1, 80);
    check(lateCnt, 1);
    send(2'h0, 16'h900a, 5'h0, 1'b1, 80);
    check(lateCnt, 1);
    farDelay = 8'd0;
    noAck = 1'b1;
    send(2'h0, 16'h0012, 5'h0, 1'b1, 6);
    check(replySuppressed, 1);
    noAck = 1'b0;
    send(2'h1, 16'h0003, 5'h0, 1'b1, 1);
    check(replySuppressed, 0);
    phase3Active = 1'b1;
    send(2'h0, 16'h1001, 5'h0, 1'b1, 1);
    ackRelease = 1'b1;
    step(1);
    ackRelease = 1'b0;
    check(goodCrcSend, 1);
    send(2'h0, 16'h1001, 5'h0, 1'b1, 1);
    n = 0;
    while (goodCrcSend !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    if (n == 100) begin
      nFail++;
      finalReport();
    end
    check(n >= HOLDC - 3 && n <= HOLDC + 3, 1);
    phase3Active = 1'b0;
    step(2);
    send(2'h0, 16'h0009, 5'h0, 1'b1, 2);
    send(2'h0, 16'h000c, 5'h0, 1'b1, 2);
    swapBlocked = 1'b1;
    send(2'h0, 16'h0009, 5'h0, 1'b1, 2);
    swapBlocked = 1'b0;
    step(RETRYC);
    send(2'h0, 16'h0009, 5'h0, 1'b1, 4);
    stall = 1'b1;
    send(2'h0, 16'h0012, 5'h0, 1'b1, 1);
    void'(expQ.pop_back());
    rxCableReset = 1'b1;
    step(1);
    rxCableReset = 1'b0;
    check({hardResetRelay, fwdValid}, 2'b01);
    rxHardReset = 1'b1;
    step(1);
    rxHardReset = 1'b0;
    check({hardResetRelay, fwdValid}, 2'b10);
    stall = 1'b0;
    send(2'h0, 16'h0012, 5'h0, 1'b1, 10);
    check(expQ.size(), 0);
    check(lateCnt, 1);
    finalReport();
  end
endmodule
`default_nettype wire
